// [hdl/sda_pkg.sv]
// Constants and types for the packed saturating DSP datapath
package sda_pkg;
	localparam logic [6:0] SDA_OPC_GRP1 = 7'h7F;
	localparam logic [6:0] SDA_OPC_GRP2 = 7'h7B;
	localparam logic [2:0] SDA_F3_GRP1 = 3'h7;
	localparam logic [2:0] SDA_F3_GRP2 = 3'h0;
	localparam logic [6:0] SDA_F7_SHIFT16 = 7'h2B;
	localparam logic [6:0] SDA_F7_ADD8 = 7'h0C;
	localparam logic [6:0] SDA_F7_ADD16 = 7'h08;
	localparam logic [6:0] SDA_F7_SUB8 = 7'h0D;
	localparam logic [6:0] SDA_F7_SUB16 = 7'h09;
	localparam logic [6:0] SDA_F7_QMUL7 = 7'h00;
	localparam logic [6:0] SDA_F7_QMUL15 = 7'h01;
	localparam logic [6:0] SDA_F7_MULHS = 7'h02;
	localparam logic [6:0] SDA_F7_MULHU = 7'h03;
	localparam int SDA_F7_POS = 25;
	localparam int SDA_F3_POS = 12;
	localparam int SDA_Q7_SHIFT = 7;
	localparam int SDA_Q15_SHIFT = 15;
	localparam logic [4:0] SDA_SHAMT_NEG16 = 5'h10;
	localparam logic [4:0] SDA_SHAMT_NEG15 = 5'h11;
	localparam logic [7:0] SDA_B_MAX = 8'h7F;
	localparam logic [7:0] SDA_B_MIN = 8'h80;
	localparam logic [15:0] SDA_H_MAX = 16'h7FFF;
	localparam logic [15:0] SDA_H_MIN = 16'h8000;
	localparam logic [63:0] SDA_RESULT_RST = 64'h0;
	// Rounding constant added to the unsigned product before taking the high word
	localparam logic [63:0] SDA_ROUND_ADD = 64'h0000_0000_8000_0000;
	typedef enum logic [9:0] {
		SDA_OP_NONE = 10'h001,
		SDA_OP_SHIFT16 = 10'h002,
		SDA_OP_ADD8 = 10'h004,
		SDA_OP_ADD16 = 10'h008,
		SDA_OP_SUB8 = 10'h010,
		SDA_OP_SUB16 = 10'h020,
		SDA_OP_QMUL7 = 10'h040,
		SDA_OP_QMUL15 = 10'h080,
		SDA_OP_MULHS = 10'h100,
		SDA_OP_MULHU = 10'h200
	} sda_op_t;
endpackage

// [hdl/sda_word_mul.sv]
// One 32x32 multiplier lane giving the high word, signed or rounded unsigned
`timescale 1ns/100ps
module sda_word_mul
	import sda_pkg::*;
(
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	input wire logic is_signed,
	output logic [31:0] hi
);
	logic [63:0] prod_s;
	logic [63:0] prod_u;
	logic [63:0] prod_r;
	assign prod_s = 64'($signed(a) * $signed(b));
	assign prod_u = {32'h0, a} * {32'h0, b};
	assign prod_r = prod_u + SDA_ROUND_ADD;
	assign hi = is_signed ? prod_s[63:32] : prod_r[63:32];
endmodule // sda_word_mul

// [hdl/sda_alu.sv]
// Packed saturating DSP datapath with one register stage
`timescale 1ns/100ps
module sda_alu
	import sda_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] rs1,
	input wire logic [63:0] rs2,
	output logic result_valid,
	output logic [63:0] result,
	output logic overflow_set,
	output logic exception
);
	function automatic logic [7:0] sat_b(input logic [8:0] s);
		sat_b = (s[8] != s[7]) ? (s[8] ? SDA_B_MIN : SDA_B_MAX) : s[7:0];
	endfunction
	function automatic logic [15:0] sat_h(input logic [16:0] s);
		sat_h = (s[16] != s[15]) ? (s[16] ? SDA_H_MIN : SDA_H_MAX) : s[15:0];
	endfunction

	// Lane out of range when the extended sign and the top bit disagree
	function automatic logic ovf_b(input logic [8:0] s);
		ovf_b = s[8] != s[7];
	endfunction
	function automatic logic ovf_h(input logic [16:0] s);
		ovf_h = s[16] != s[15];
	endfunction

	sda_op_t op;
	logic [6:0] f7;
	logic [2:0] f3;
	logic [6:0] opc;
	logic grp1;
	logic grp2;
	assign f7 = instr[SDA_F7_POS +: 7];
	assign f3 = instr[SDA_F3_POS +: 3];
	assign opc = instr[6:0];
	assign grp1 = (opc == SDA_OPC_GRP1) && (f3 == SDA_F3_GRP1);
	assign grp2 = (opc == SDA_OPC_GRP2) && (f3 == SDA_F3_GRP2);

	// Decode only while an issue is presented
	always_comb
	begin
		op = SDA_OP_NONE;
		if (issue_valid && grp1)
		begin
			case (f7)
				SDA_F7_SHIFT16: op = SDA_OP_SHIFT16;
				SDA_F7_ADD8: op = SDA_OP_ADD8;
				SDA_F7_ADD16: op = SDA_OP_ADD16;
				SDA_F7_SUB8: op = SDA_OP_SUB8;
				SDA_F7_SUB16: op = SDA_OP_SUB16;
				default: op = SDA_OP_NONE;
			endcase
		end
		else if (issue_valid && grp2)
		begin
			case (f7)
				SDA_F7_QMUL7: op = SDA_OP_QMUL7;
				SDA_F7_QMUL15: op = SDA_OP_QMUL15;
				SDA_F7_MULHS: op = SDA_OP_MULHS;
				SDA_F7_MULHU: op = SDA_OP_MULHU;
				default: op = SDA_OP_NONE;
			endcase
		end
	end

	// Byte add and subtract, eight lanes
	logic [63:0] add8_res;
	logic [63:0] sub8_res;
	logic [7:0] add8_ov;
	logic [7:0] sub8_ov;
	logic [8:0] add8_s [8];
	logic [8:0] sub8_s [8];
	for (genvar i = 0; i < 8; i++)
	begin : g_b
		assign add8_s[i] = {rs1[8*i+7], rs1[8*i +: 8]} + {rs2[8*i+7], rs2[8*i +: 8]};
		assign sub8_s[i] = {rs1[8*i+7], rs1[8*i +: 8]} - {rs2[8*i+7], rs2[8*i +: 8]};
		assign add8_res[8*i +: 8] = sat_b(add8_s[i]);
		assign sub8_res[8*i +: 8] = sat_b(sub8_s[i]);
		assign add8_ov[i] = ovf_b(add8_s[i]);
		assign sub8_ov[i] = ovf_b(sub8_s[i]);
	end

	// Halfword add, subtract and shift, four lanes
	logic [4:0] sh_ctl;
	logic sh_neg;
	logic [3:0] sh_right;
	logic [3:0] sh_left;
	assign sh_ctl = rs2[4:0];
	assign sh_neg = sh_ctl[4];
	// Minus sixteen folded onto minus fifteen
	assign sh_right = (sh_ctl == SDA_SHAMT_NEG16) ? 4'(-SDA_SHAMT_NEG15) : 4'(-sh_ctl);
	assign sh_left = sh_ctl[3:0];

	// Left shift kept in 31 bits so any overflow stays visible
	logic [63:0] add16_res;
	logic [63:0] sub16_res;
	logic [63:0] sh16_res;
	logic [3:0] add16_ov;
	logic [3:0] sub16_ov;
	logic [3:0] sh16_ov;
	logic [16:0] add16_s [4];
	logic [16:0] sub16_s [4];
	logic [30:0] shl_w [4];
	logic [15:0] shr_w [4];
	logic [3:0] shl_pos;
	logic [3:0] shl_neg;
	for (genvar i = 0; i < 4; i++)
	begin : g_h
		assign add16_s[i] = {rs1[16*i+15], rs1[16*i +: 16]} + {rs2[16*i+15], rs2[16*i +: 16]};
		assign sub16_s[i] = {rs1[16*i+15], rs1[16*i +: 16]} - {rs2[16*i+15], rs2[16*i +: 16]};
		assign add16_res[16*i +: 16] = sat_h(add16_s[i]);
		assign sub16_res[16*i +: 16] = sat_h(sub16_s[i]);
		assign add16_ov[i] = ovf_h(add16_s[i]);
		assign sub16_ov[i] = ovf_h(sub16_s[i]);
		assign shl_w[i] = 31'($signed(rs1[16*i +: 16])) << sh_left;
		assign shr_w[i] = 16'($signed(rs1[16*i +: 16]) >>> sh_right);
		// Out of range when bits 30..15 are not all equal
		assign shl_pos[i] = !shl_w[i][30] && (shl_w[i][29:15] != 15'h0);
		assign shl_neg[i] = shl_w[i][30] && (shl_w[i][29:15] != 15'h7FFF);
		assign sh16_res[16*i +: 16] = sh_neg ? shr_w[i] :
			shl_pos[i] ? SDA_H_MAX : shl_neg[i] ? SDA_H_MIN : shl_w[i][15:0];
		assign sh16_ov[i] = !sh_neg && (shl_pos[i] || shl_neg[i]);
	end

	// Crossed fractional multiplies
	logic [63:0] q7_res;
	logic [7:0] q7_ov;
	logic [7:0] q7_a [8];
	logic [7:0] q7_b [8];
	logic [15:0] q7_p [8];
	for (genvar i = 0; i < 8; i++)
	begin : g_q7
		// Odd lane: rs1 upper by rs2 lower; even lane: rs1 lower by rs2 upper
		assign q7_a[i] = rs1[8*i +: 8];
		assign q7_b[i] = rs2[8*(i ^ 1) +: 8];
		assign q7_p[i] = 16'($signed(q7_a[i]) * $signed(q7_b[i]));
		// Only the most negative square leaves the Q7 range
		assign q7_ov[i] = (q7_a[i] == SDA_B_MIN) && (q7_b[i] == SDA_B_MIN);
		assign q7_res[8*i +: 8] = q7_ov[i] ? SDA_B_MAX : q7_p[i][SDA_Q7_SHIFT +: 8];
	end

	logic [63:0] q15_res;
	logic [3:0] q15_ov;
	logic [15:0] q15_a [4];
	logic [15:0] q15_b [4];
	logic [31:0] q15_p [4];
	for (genvar i = 0; i < 4; i++)
	begin : g_q15
		assign q15_a[i] = rs1[16*i +: 16];
		assign q15_b[i] = rs2[16*(i ^ 1) +: 16];
		assign q15_p[i] = 32'($signed(q15_a[i]) * $signed(q15_b[i]));
		// Only the most negative square leaves the Q15 range
		assign q15_ov[i] = (q15_a[i] == SDA_H_MIN) && (q15_b[i] == SDA_H_MIN);
		assign q15_res[16*i +: 16] = q15_ov[i] ? SDA_H_MAX : q15_p[i][SDA_Q15_SHIFT +: 16];
	end

	// High-word multiplies, two lanes
	logic [63:0] mulh_res;
	logic mulh_signed;
	// Both lanes share one signedness select; these never saturate
	assign mulh_signed = (op == SDA_OP_MULHS);
	sda_word_mul u_mul_lo (
		.a(rs1[31:0]),
		.b(rs2[31:0]),
		.is_signed(mulh_signed),
		.hi(mulh_res[31:0])
	);
	sda_word_mul u_mul_hi (
		.a(rs1[63:32]),
		.b(rs2[63:32]),
		.is_signed(mulh_signed),
		.hi(mulh_res[63:32])
	);

	// Unsupported codes leave result and overflow at zero
	logic [63:0] sel_res;
	logic sel_ov;
	always_comb
	begin
		sel_res = SDA_RESULT_RST;
		sel_ov = 1'b0;
		case (op)
			SDA_OP_SHIFT16:
			begin
				sel_res = sh16_res;
				sel_ov = |sh16_ov;
			end
			SDA_OP_ADD8:
			begin
				sel_res = add8_res;
				sel_ov = |add8_ov;
			end
			SDA_OP_ADD16:
			begin
				sel_res = add16_res;
				sel_ov = |add16_ov;
			end
			SDA_OP_SUB8:
			begin
				sel_res = sub8_res;
				sel_ov = |sub8_ov;
			end
			SDA_OP_SUB16:
			begin
				sel_res = sub16_res;
				sel_ov = |sub16_ov;
			end
			SDA_OP_QMUL7:
			begin
				sel_res = q7_res;
				sel_ov = |q7_ov;
			end
			SDA_OP_QMUL15:
			begin
				sel_res = q15_res;
				sel_ov = |q15_ov;
			end
			SDA_OP_MULHS, SDA_OP_MULHU: sel_res = mulh_res;
			default:
			begin
				sel_res = SDA_RESULT_RST;
				sel_ov = 1'b0;
			end
		endcase
	end

	logic valid_next;
	logic [63:0] result_next;
	logic ovf_next;
	assign valid_next = (op != SDA_OP_NONE);
	// Idle cycles present zero on the result
	assign result_next = valid_next ? sel_res : SDA_RESULT_RST;
	// Set-only pulse; the host keeps the sticky flag
	assign ovf_next = valid_next && sel_ov;
	logic [63:0] result_reg;
	logic valid_reg;
	logic ovf_reg;
	logic exc_reg;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			result_reg <= SDA_RESULT_RST;
		else
			result_reg <= result_next;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			valid_reg <= 1'b0;
		else
			valid_reg <= valid_next;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			ovf_reg <= 1'b0;
		else
			ovf_reg <= ovf_next;
	end

	// Constant-zero register: these operations never trap at any privilege
	always_ff @(posedge clk)
	begin
		if (!nrst)
			exc_reg <= 1'b0;
		else
			exc_reg <= 1'b0;
	end

	assign result = result_reg;
	assign result_valid = valid_reg;
	assign overflow_set = ovf_reg;
	assign exception = exc_reg;
endmodule // sda_alu

// [verif/sda_alu_asserts.sv]
// Concurrent checks on the saturating DSP datapath ports
`timescale 1ns/100ps
module sda_alu_chk
	import sda_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] rs1,
	input wire logic [63:0] rs2,
	input wire logic result_valid,
	input wire logic [63:0] result,
	input wire logic overflow_set,
	input wire logic exception
);
	wire logic [6:0] f7 = instr[31:25];
	wire logic g1 = issue_valid && {instr[14:12], instr[6:0]} == {SDA_F3_GRP1, SDA_OPC_GRP1};
	wire logic g2 = issue_valid && {instr[14:12], instr[6:0]} == {SDA_F3_GRP2, SDA_OPC_GRP2};
	wire logic dec = g1 && f7 inside {SDA_F7_SHIFT16, SDA_F7_ADD8, SDA_F7_ADD16, SDA_F7_SUB8,
		SDA_F7_SUB16} || g2 && f7 < 7'h04;
	wire logic q7 = g2 && f7 == SDA_F7_QMUL7 && rs1[15:8] == SDA_B_MIN && rs2[7:0] == SDA_B_MIN;
	wire logic q15 = g2 && f7 == SDA_F7_QMUL15 && rs1[31:16] == SDA_H_MIN
		&& rs2[15:0] == SDA_H_MIN;
	wire logic sh = g1 && f7 == SDA_F7_SHIFT16 && rs2[4:0] == SDA_SHAMT_NEG16;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		dec;
	endsequence
	sequence s_quiet;
		!result_valid && !overflow_set && result == 64'h0;
	endsequence
	a_take_answer: assert property (s_take |=> result_valid)
		else $error("no result one cycle after a decoded issue");
	a_refuse_quiet: assert property (issue_valid && !dec |=> s_quiet)
		else $error("undecoded issue produced output");
	a_no_exception: assert property (exception == 1'b0)
		else $error("exception raised");
	a_ov_with_result: assert property (overflow_set |-> result_valid)
		else $error("overflow pulse without result");
	a_q7_clamp: assert property (q7 |=> overflow_set && result[15:8] == SDA_B_MAX)
		else $error("q7 corner not clamped");
	a_q15_clamp: assert property (q15 |=> overflow_set && result[31:16] == SDA_H_MAX)
		else $error("q15 corner not clamped");
	a_mulh_no_ov: assert property (g2 && f7[6:1] == 6'h01 |=> !overflow_set)
		else $error("high word multiply flagged overflow");
	a_neg16_sign: assert property (sh |=> result[15:0] == {16{$past(rs1[15])}})
		else $error("shift of minus sixteen not sign fill");
endmodule // sda_alu_chk
bind sda_alu sda_alu_chk u_chk(.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
	.instr(instr), .rs1(rs1), .rs2(rs2), .result_valid(result_valid), .result(result),
	.overflow_set(overflow_set), .exception(exception));

// [verif/sda_issue_model.sv]
// Issue stage and overflow flag of the host pipeline
`timescale 1ns/100ps
module sda_issue_model
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic go,
	input wire logic [31:0] go_i,
	input wire logic [63:0] go_a,
	input wire logic [63:0] go_b,
	input wire logic overflow_set,
	output logic issue_valid,
	output logic [31:0] instr,
	output logic [63:0] rs1,
	output logic [63:0] rs2,
	output logic overflow_flag
);
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			issue_valid <= 1'b0;
			instr <= 32'h0;
			rs1 <= 64'h0;
			rs2 <= 64'h0;
			overflow_flag <= 1'b0;
		end
		else
		begin
			issue_valid <= go;
			instr <= go ? go_i : ~instr;
			rs1 <= go ? go_a : ~rs1;
			rs2 <= go ? go_b : ~rs2;
			overflow_flag <= overflow_flag | overflow_set;
		end
	end
endmodule // sda_issue_model

// [verif/test_simd_saturating_dsp_alu.sv]
// Self-checking bench for the saturating DSP datapath
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module test_simd_saturating_dsp_alu
	import sda_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic go = 1'b0;
	logic [31:0] go_i = 32'h0;
	logic [63:0] go_a = 64'h0;
	logic [63:0] go_b = 64'h0;
	logic issue_valid, result_valid, overflow_set, exception, overflow_flag, ov, v;
	logic [31:0] instr;
	logic [63:0] rs1, rs2, result, r;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	sda_issue_model u_issue(.clk(clk), .nrst(nrst), .go(go), .go_i(go_i), .go_a(go_a),
		.go_b(go_b), .overflow_set(overflow_set), .issue_valid(issue_valid), .instr(instr),
		.rs1(rs1), .rs2(rs2), .overflow_flag(overflow_flag));
	sda_alu dut(.clk(clk), .nrst(nrst), .issue_valid(issue_valid), .instr(instr), .rs1(rs1),
		.rs2(rs2), .result_valid(result_valid), .result(result), .overflow_set(overflow_set),
		.exception(exception));
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			mismatches++;
			finish_test();
		end
	end
	// Issue one instruction, sample the answer one edge after it is taken
	task automatic run(input logic [6:0] f7, input logic g2, input logic [63:0] a, b);
		@(posedge clk);
		go <= 1'b1;
		go_i <= {f7, 10'h0, g2 ? SDA_F3_GRP2 : SDA_F3_GRP1, 5'h0, g2 ? SDA_OPC_GRP2 : SDA_OPC_GRP1};
		go_a <= a;
		go_b <= b;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		r = result;
		ov = overflow_set;
		v = result_valid;
		`CHK(exception, 1'b0)
	endtask
	task automatic got(input logic [63:0] er, input logic eov);
		`CHK(v, 1'b1)
		`CHK(r, er)
		`CHK(ov, eov)
	endtask
	task automatic t_shift();
		run(SDA_F7_SHIFT16, 1'b0, 64'h1234_C000_4000_0001, 64'hFFFF_FFFF_FFFF_FFE3);
		got(64'h7FFF_8000_7FFF_0008, 1'b1);
		run(SDA_F7_SHIFT16, 1'b0, 64'h8000_7FF0_FFFF_0100, 64'hFFFF_FFFF_FFFF_FFFC);
		got(64'hF800_07FF_FFFF_0010, 1'b0);
		run(SDA_F7_SHIFT16, 1'b0, 64'h8000_7FFF_1234_C000, 64'hFFFF_FFFF_FFFF_FFF0);
		got(64'hFFFF_0000_0000_FFFF, 1'b0);
	endtask
	task automatic t_add();
		run(SDA_F7_ADD8, 1'b0, 64'h7F80_01FF_40C0_1000, 64'h01FF_01FF_40C0_F000);
		got(64'h7F80_02FE_7F80_0000, 1'b1);
		run(SDA_F7_ADD8, 1'b0, 64'h7F80_01FF_40C0_1000, 64'h0);
		got(64'h7F80_01FF_40C0_1000, 1'b0);
		`CHK(overflow_flag, 1'b1)
		run(SDA_F7_ADD16, 1'b0, 64'h7FFF_8000_1234_C000, 64'h0001_FFFF_1111_C000);
		got(64'h7FFF_8000_2345_8000, 1'b1);
	endtask
	task automatic t_sub();
		run(SDA_F7_SUB8, 1'b0, 64'h807F_0500_0000_0080, 64'h01FF_0700_0000_0000);
		got(64'h807F_FE00_0000_0080, 1'b1);
		run(SDA_F7_SUB16, 1'b0, 64'h8000_7FFF_0005_0000, 64'h0001_FFFF_0007_8000);
		got(64'h8000_7FFF_FFFE_7FFF, 1'b1);
	endtask
	task automatic t_mul();
		run(SDA_F7_QMUL7, 1'b1, 64'h0000_8000_4020_80C0, 64'h0000_007F_1040_4080);
		got(64'h0000_8100_2004_7FE0, 1'b1);
		run(SDA_F7_QMUL15, 1'b1, 64'h4000_2000_8000_C000, 64'h1000_4000_4000_8000);
		got(64'h2000_0400_7FFF_E000, 1'b1);
		run(SDA_F7_MULHS, 1'b1, 64'h4000_0000_FFFF_FFFF, 64'h0000_0004_0000_0002);
		got(64'h0000_0001_FFFF_FFFF, 1'b0);
		run(SDA_F7_MULHU, 1'b1, 64'h4000_0000_FFFF_FFFF, 64'h0000_0004_0000_0002);
		got(64'h0000_0001_0000_0002, 1'b0);
	endtask
	task automatic t_refuse();
		run(SDA_F7_QMUL7, 1'b0, 64'h8080_8080_8080_8080, 64'h8080_8080_8080_8080);
		`CHK(v, 1'b0)
		run(SDA_F7_ADD8, 1'b1, 64'h7F7F_7F7F_7F7F_7F7F, 64'h7F7F_7F7F_7F7F_7F7F);
		`CHK(r, 64'h0)
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_shift();
		t_add();
		t_sub();
		t_mul();
		t_refuse();
		finish_test();
	end
endmodule // test_simd_saturating_dsp_alu
